/* File: design/diag_status_regs.sv */
// diagnostic status register bank: supply, bus, thermal and reset cause
//
// Operation
// - ldo3 flag sets raise interrupt bits 7,6
// - ldo2 flag sets raise interrupt bits 5,4
// - 5v flag sets raise interrupt bits 3,2
// - battery flag sets raise interrupt bits 1,0
// - bus dominant clamp shown in bit 7
// - txd/rxd short shown in bit 6
// - rxd recessive clamp shown in bit 5
// - txd dominant clamp shown in bit 4
// - canl supply/ground shorts in bits 3,2
// - canh ground/supply shorts in bits 1,0
// - 140 degree recovery in thermal bit 1
// - 160 degree warning in thermal bit 0
// - reading reset cause clears all bits except those set by an event in the same cycle
// - local wake exit sets cause bit 6
// - remote wake exit sets cause bit 5
// - offset 0x10 holds fuse bits 32..25
// - offset 0x11 holds fuse bits 40..33
`timescale 1ns/1ps
`default_nettype none
module diag_status_regs #(
  parameter int DATA_W = 8 // register width of the serial map
) (
  input wire logic sys_clk_i, // 10 MHz system clock
  input wire logic srst_i, // synchronous reset, active high
  input wire diag_status_pkg::reg_req_t req_i, // register access
  input wire diag_status_pkg::supply_flags_t supply_i, // live monitors
  input wire diag_status_pkg::bus_faults_t bus_i, // can fault levels
  input wire diag_status_pkg::thermal_flags_t thermal_i, // thermal levels
  input wire diag_status_pkg::reset_events_t events_i, // cause pulses
  input wire logic [15:0] fuse_i, // fuse bits 40..25, loaded in reset
  output logic [7:0] rdata_o, // read data, valid with rvalid_o
  output logic rvalid_o, // one-cycle read answer strobe
  output logic [7:0] int_src_o // sticky supply interrupt sources
);

  // the map is byte wide; any other width cannot be served
  if (DATA_W != 8) begin : g_bad_width
    $error("diag_status_regs supports only 8-bit registers");
  end

  // whole state and its next value
  diag_status_pkg::diag_state_t state;
  diag_status_pkg::diag_state_t next_state;

  // rising edges of the supply flags against the last sampled copy
  logic [7:0] supply_rise;
  // reads and writes decoded per register
  logic rd_cause;
  logic wr_src;

  // edge detect uses the supply status register as the previous sample
  assign supply_rise = supply_i & ~state.sup_st;
  // read of the reset cause register
  assign rd_cause = req_i.rd && req_i.addr == diag_status_pkg::OFS_RESET_CAUSE;
  // write to the interrupt source register
  assign wr_src = req_i.wr &&
    req_i.addr == diag_status_pkg::OFS_SUPPLY_INT_SRC;

  // next state of the bank
  always_comb begin
    next_state = state;
    // interrupt sources: write one clears, a new edge wins over a clear
    next_state.int_src = (state.int_src & ~(wr_src ? req_i.wdata : 8'h00))
      | supply_rise;
    // live mirrors of the detectors
    next_state.bus_st = bus_i;
    next_state.therm = thermal_i;
    next_state.sup_st = supply_i;
    // reset cause: read clears, an event in the same cycle survives
    if (rd_cause) begin
      next_state.cause = diag_status_pkg::RST_RESET_CAUSE;
    end
    // events set their bit; bit 7 stays reserved at zero
    next_state.cause = next_state.cause | events_i;
    next_state.cause.reserved = 1'b0;
    // backup bytes take writes from the microcontroller
    if (req_i.wr && req_i.addr == diag_status_pkg::OFS_BACKUP_0) begin
      next_state.backup0 = req_i.wdata;
    end
    if (req_i.wr && req_i.addr == diag_status_pkg::OFS_BACKUP_1) begin
      next_state.backup1 = req_i.wdata;
    end
    // read answer one cycle after the request
    next_state.rvalid = req_i.rd;
    next_state.rdata = state.rdata;
    if (req_i.rd) begin
      case (req_i.addr)
        diag_status_pkg::OFS_SUPPLY_INT_SRC: begin
          next_state.rdata = state.int_src;
        end
        diag_status_pkg::OFS_BUS_FAULT: begin
          next_state.rdata = state.bus_st;
        end
        diag_status_pkg::OFS_THERMAL: begin
          // bits 7..2 reserved, read as zero
          next_state.rdata = {6'h00, state.therm};
        end
        diag_status_pkg::OFS_SUPPLY_FLAG: begin
          next_state.rdata = state.sup_st;
        end
        diag_status_pkg::OFS_RESET_CAUSE: begin
          next_state.rdata = state.cause;
        end
        diag_status_pkg::OFS_BACKUP_0: begin
          next_state.rdata = state.backup0;
        end
        diag_status_pkg::OFS_BACKUP_1: begin
          next_state.rdata = state.backup1;
        end
        default: begin
          // reserved 0x0b and unmapped offsets
          next_state.rdata = diag_status_pkg::UNMAPPED_READ;
        end
      endcase
    end
  end

  // state register; reset loads fuse copies into the backup bytes
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state.int_src <= diag_status_pkg::RST_SUPPLY_INT_SRC;
      state.bus_st <= diag_status_pkg::RST_BUS_FAULT;
      state.therm <= diag_status_pkg::RST_THERMAL[1:0];
      state.sup_st <= diag_status_pkg::RST_SUPPLY_FLAG;
      state.cause <= diag_status_pkg::RST_RESET_CAUSE;
      state.backup0 <= fuse_i[7:0];
      state.backup1 <= fuse_i[15:8];
      state.rdata <= diag_status_pkg::UNMAPPED_READ;
      state.rvalid <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from the state flops
  assign rdata_o = state.rdata;
  assign rvalid_o = state.rvalid;
  assign int_src_o = state.int_src;

  // ldo3 power-good edge lands in interrupt bit 7
  a_src_ldo3_set: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    supply_i.ldo3_power_good_flag && !state.sup_st.ldo3_power_good_flag
    |=> int_src_o[7] && state.sup_st.ldo3_power_good_flag)
    else $error("ldo3 power-good edge not latched");

  // ldo2 undervoltage edge lands in bit 4 and holds without a clear
  a_src_ldo2_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    supply_i.ldo2_undervoltage_flag && !state.sup_st.ldo2_undervoltage_flag
    ##1 !wr_src |=> int_src_o[4])
    else $error("ldo2 undervoltage source lost");

  // five volt undervoltage edge lands in bit 2 even under a clear
  a_src_five_wins: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    supply_rise[2] && wr_src && req_i.wdata[2] |=> int_src_o[2])
    else $error("clear beat the 5v undervoltage edge");

  // battery bits clear only by a write of one
  a_src_batt_clear: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    wr_src && req_i.wdata[1:0] == 2'b11 && supply_rise[1:0] == 2'b00
    |=> int_src_o[1:0] == 2'b00)
    else $error("battery sources not cleared");

  // bus faults read back what was present two cycles before the answer
  a_bus_readback: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ##1 req_i.rd && req_i.addr == diag_status_pkg::OFS_BUS_FAULT
    |=> rvalid_o && rdata_o == $past(bus_i, 2))
    else $error("bus status read mismatch");

  // thermal read carries zero in the reserved bits
  a_therm_reserved: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    req_i.rd && req_i.addr == diag_status_pkg::OFS_THERMAL
    |=> rdata_o[7:2] == 6'h00 && rdata_o[1:0] == $past(state.therm))
    else $error("thermal read wrong");

  // a quiet read of the reset cause leaves it empty
  a_cause_clear: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    rd_cause && events_i == 8'h00 |=> state.cause == 8'h00)
    else $error("reset cause not cleared by read");

  // wake events survive a same-cycle read and show on the next read
  a_cause_wake: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    events_i.local_wake && events_i.remote_wake
    |=> state.cause[6:5] == 2'b11)
    else $error("wake cause lost");

  // backup byte written then read returns the written value
  a_backup_rw: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    req_i.wr && req_i.addr == diag_status_pkg::OFS_BACKUP_1 ##1
    req_i.rd && !req_i.wr && req_i.addr == diag_status_pkg::OFS_BACKUP_1
    |=> rdata_o == $past(req_i.wdata, 2))
    else $error("backup byte readback wrong");

  // supply status follows the monitors one cycle late
  a_supply_live: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    1'b1 |=> state.sup_st == $past(supply_i))
    else $error("supply status not live");

  // ldo3 undervoltage edge lands in interrupt bit 6
  a_src_ldo3_uv: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    supply_rise[6] |=> int_src_o[6])
    else $error("ldo3 undervoltage edge not latched");

  // ldo2 power-good edge lands in interrupt bit 5
  a_src_ldo2_pg: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    supply_rise[5] |=> int_src_o[5])
    else $error("ldo2 power-good edge not latched");

  // ldo2 undervoltage edge lands in interrupt bit 4
  a_src_ldo2_uv: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    supply_rise[4] |=> int_src_o[4])
    else $error("ldo2 undervoltage edge not latched");

  // five volt power-good edge lands in interrupt bit 3
  a_src_five_pg: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    supply_rise[3] |=> int_src_o[3])
    else $error("5v power-good edge not latched");

  // battery power-good edge lands in interrupt bit 1
  a_src_batt_pg: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    supply_rise[1] |=> int_src_o[1])
    else $error("battery power-good edge not latched");

  // battery undervoltage edge lands in interrupt bit 0
  a_src_batt_uv: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    supply_rise[0] |=> int_src_o[0])
    else $error("battery undervoltage edge not latched");

  // sources never change without an edge or a clearing write
  a_src_quiet: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !wr_src && supply_rise == 8'h00 |=> int_src_o == $past(int_src_o))
    else $error("interrupt source changed on its own");

  // a clearing write of bit 7 with no new edge empties it
  a_src_ldo3_clr: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    wr_src && req_i.wdata[7] && !supply_rise[7] |=> !int_src_o[7])
    else $error("ldo3 power-good source not cleared");

  // a read of the source register returns the sticky bits
  a_src_read: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    req_i.rd && req_i.addr == diag_status_pkg::OFS_SUPPLY_INT_SRC
    |=> rdata_o == $past(int_src_o))
    else $error("interrupt source read wrong");

  // bus status mirrors the fault detectors one cycle late
  a_bus_live: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    1'b1 |=> state.bus_st == $past(bus_i))
    else $error("bus status not live");

  // thermal status mirrors the thermal monitor one cycle late
  a_therm_live: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    1'b1 |=> state.therm == $past(thermal_i))
    else $error("thermal status not live");

  // every cause event in bits 6..0 sets its own bit on the next edge
  a_cause_events: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    events_i != 8'h00
    |=> (state.cause[6:0] & $past(events_i[6:0])) == $past(events_i[6:0]))
    else $error("reset cause event lost");

  // the reserved cause bit never sets
  a_cause_rsvd: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !state.cause.reserved)
    else $error("reserved cause bit set");

  // without a read or an event the cause register holds
  a_cause_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !rd_cause && events_i == 8'h00 |=> state.cause == $past(state.cause))
    else $error("reset cause changed on its own");

  // a cause read returns the value before the clear
  a_cause_rdval: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    rd_cause |=> rdata_o == $past(state.cause))
    else $error("reset cause read wrong");

  // a local wake arriving with a read survives the clear
  a_cause_lwake: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    rd_cause && events_i.local_wake |=> state.cause.local_wake)
    else $error("local wake lost under read");

  // a remote wake arriving with a read survives the clear
  a_cause_rwake: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    rd_cause && events_i.remote_wake |=> state.cause.remote_wake)
    else $error("remote wake lost under read");

  // the answer strobe follows each read by exactly one cycle
  a_rvalid_pulse: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    1'b1 |=> rvalid_o == $past(req_i.rd))
    else $error("read answer strobe wrong");

  // read data holds while no read is made
  a_rdata_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !req_i.rd |=> rdata_o == $past(rdata_o))
    else $error("read data changed without a read");

  // first backup byte takes a write
  a_backup0_wr: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    req_i.wr && req_i.addr == diag_status_pkg::OFS_BACKUP_0
    |=> state.backup0 == $past(req_i.wdata))
    else $error("backup byte 0 write lost");

  // first backup byte holds without a write to it
  a_backup0_keep: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !(req_i.wr && req_i.addr == diag_status_pkg::OFS_BACKUP_0)
    |=> state.backup0 == $past(state.backup0))
    else $error("backup byte 0 changed");

  // second backup byte takes a write
  a_backup1_wr: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    req_i.wr && req_i.addr == diag_status_pkg::OFS_BACKUP_1
    |=> state.backup1 == $past(req_i.wdata))
    else $error("backup byte 1 write lost");

  // second backup byte holds without a write to it
  a_backup1_keep: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !(req_i.wr && req_i.addr == diag_status_pkg::OFS_BACKUP_1)
    |=> state.backup1 == $past(state.backup1))
    else $error("backup byte 1 changed");

  // a supply status read returns the live copy
  a_supply_read: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    req_i.rd && req_i.addr == diag_status_pkg::OFS_SUPPLY_FLAG
    |=> rdata_o == $past(state.sup_st))
    else $error("supply status read wrong");

endmodule
`default_nettype wire

/* File: pkg/diag_status_pkg.sv */
// package with register map, field layouts and carriers of the diag block
package diag_status_pkg;

  // register offsets on the serial register port
  localparam logic [7:0] OFS_SUPPLY_INT_SRC = 8'h0a;
  localparam logic [7:0] OFS_RESERVED_0B = 8'h0b;
  localparam logic [7:0] OFS_BUS_FAULT = 8'h0c;
  localparam logic [7:0] OFS_THERMAL = 8'h0d;
  localparam logic [7:0] OFS_SUPPLY_FLAG = 8'h0e;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h0f;
  localparam logic [7:0] OFS_BACKUP_0 = 8'h10;
  localparam logic [7:0] OFS_BACKUP_1 = 8'h11;

  // reset values
  localparam logic [7:0] RST_SUPPLY_INT_SRC = 8'h00;
  localparam logic [7:0] RST_BUS_FAULT = 8'h00;
  localparam logic [7:0] RST_THERMAL = 8'h00;
  localparam logic [7:0] RST_SUPPLY_FLAG = 8'haa;
  localparam logic [7:0] RST_RESET_CAUSE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // supply flags, bit 7 down to bit 0 of both supply registers
  typedef struct packed {
    logic ldo3_power_good_flag;
    logic ldo3_undervoltage_flag;
    logic ldo2_power_good_flag;
    logic ldo2_undervoltage_flag;
    logic five_volt_power_good_flag;
    logic five_volt_undervoltage_flag;
    logic battery_power_good_flag;
    logic battery_undervoltage_flag;
  } supply_flags_t;

  // can fault detector levels, bit 7 down to bit 0
  typedef struct packed {
    logic bus_dominant_clamp;
    logic txd_rxd_short;
    logic rxd_recessive_clamp;
    logic txd_dominant_clamp;
    logic canl_short_supply;
    logic canl_short_ground;
    logic canh_short_ground;
    logic canh_short_supply;
  } bus_faults_t;

  // thermal monitor levels, bit 1 and bit 0
  typedef struct packed {
    logic recovery_140;
    logic warning_160;
  } thermal_flags_t;

  // reset cause event pulses, bit 7 down to bit 0
  typedef struct packed {
    logic reserved;
    logic local_wake;
    logic remote_wake;
    logic window_watchdog;
    logic timeout_watchdog;
    logic startup_watchdog;
    logic ldo1_undervoltage;
    logic thermal_shutdown;
  } reset_events_t;

  // register port request from the serial interface
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // whole state of the register bank
  typedef struct packed {
    logic [7:0] int_src;
    bus_faults_t bus_st;
    thermal_flags_t therm;
    supply_flags_t sup_st;
    reset_events_t cause;
    logic [7:0] backup0;
    logic [7:0] backup1;
    logic [7:0] rdata;
    logic rvalid;
  } diag_state_t;

endpackage

/* File: tb/testbench.sv */
// self-checking bench for the diagnostic status register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0; // 10 MHz bench clock
  logic srst = 1'b1; // synchronous reset, active high
  diag_status_pkg::reg_req_t req = '0; // register port request
  diag_status_pkg::supply_flags_t supply = 8'haa; // live supply flags
  diag_status_pkg::bus_faults_t bus = 8'h00; // can fault levels
  diag_status_pkg::thermal_flags_t thermal = 2'h0; // thermal levels
  diag_status_pkg::reset_events_t events = 8'h00; // reset cause pulses
  logic [15:0] fuse = 16'h5ac3; // fuse image loaded in reset
  logic [7:0] rdata; // read data
  logic rvalid; // read answer strobe
  logic [7:0] int_src; // sticky interrupt sources
  int error_cnt = 0; // mismatches seen
  int total_checks = 0; // comparisons made
  int cycles = 0; // watchdog on the run length

  // device under test
  diag_status_regs i_diag_status_regs (
    .sys_clk_i(sys_clk), .srst_i(srst), .req_i(req), .supply_i(supply),
    .bus_i(bus), .thermal_i(thermal), .events_i(events), .fuse_i(fuse),
    .rdata_o(rdata), .rvalid_o(rvalid), .int_src_o(int_src)
  );

  // clock: half period 50 ns
  always #50 sys_clk = ~sys_clk;

  // compare one value and log a mismatch
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // print counts and verdict, then stop
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one read: request for one edge, answer one cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string nm);
    @(posedge sys_clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1;
    chk("rvalid", {7'h0, rvalid}, 8'h01);
    chk(nm, rdata, exp);
  endtask

  // one write: request for one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask

  // wait a few edges, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // cut a hang short
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      error_cnt++;
      final_report();
    end
  end

  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    tick(2);
    // reset values and fuse-loaded backup bytes
    chk("int_src reset", int_src, 8'h00);
    rd(8'h0a, 8'h00, "int_src");
    rd(8'h0b, 8'h00, "reserved");
    rd(8'h0c, 8'h00, "bus reset");
    rd(8'h0d, 8'h00, "thermal reset");
    rd(8'h0e, 8'haa, "supply reset");
    rd(8'h0f, 8'h00, "cause reset");
    rd(8'h10, 8'hc3, "backup0 fuse");
    rd(8'h11, 8'h5a, "backup1 fuse");
    // even flags rise together, then odd ones
    @(posedge sys_clk) supply <= 8'h55;
    tick(2);
    chk("int_src even", int_src, 8'h55);
    @(posedge sys_clk) supply <= 8'hff;
    tick(2);
    chk("int_src all", int_src, 8'hff);
    rd(8'h0e, 8'hff, "supply live");
    wr(8'h0a, 8'h0f);
    #1;
    chk("int_src clear", int_src, 8'hf0);
    rd(8'h0a, 8'hf0, "int_src read");
    // each source alone; a falling flag sets nothing
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk) supply <= 8'h00;
      wr(8'h0a, 8'hff);
      tick(2);
      chk("int_src fall", int_src, 8'h00);
      @(posedge sys_clk) supply <= 8'h01 << i;
      tick(2);
      chk("int_src bit", int_src, 8'h01 << i);
    end
    // bus faults one by one; writes to a read-only place are ignored
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk) bus <= 8'h01 << i;
      wr(8'h0c, 8'h00);
      rd(8'h0c, 8'h01 << i, "bus bit");
    end
    // thermal flags, reserved bits stay low
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk) thermal <= 2'h1 << i;
      tick(2);
      rd(8'h0d, 8'h01 << i, "thermal bit");
    end
    // each reset cause, then cleared by the read
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk) events <= 8'h01 << i;
      @(posedge sys_clk) events <= 8'h00;
      wr(8'h0f, 8'h00);
      rd(8'h0f, (i == 7) ? 8'h00 : 8'h01 << i, "cause bit");
      rd(8'h0f, 8'h00, "cause cleared");
    end
    // both wakes arrive with a read: old value returned, wakes kept
    @(posedge sys_clk);
    events <= 8'h60;
    req.rd <= 1'b1;
    req.addr <= 8'h0f;
    @(posedge sys_clk);
    events <= 8'h00;
    req.rd <= 1'b0;
    #1;
    chk("cause race", rdata, 8'h00);
    rd(8'h0f, 8'h60, "cause wakes");
    // write and read of a backup byte back to back
    @(posedge sys_clk);
    req.wr <= 1'b1;
    req.addr <= 8'h11;
    req.wdata <= 8'h99;
    @(posedge sys_clk);
    req.wr <= 1'b0;
    req.rd <= 1'b1;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1;
    chk("backup1 b2b", rdata, 8'h99);
    // backup bytes are writable; reserved and unmapped read zero
    wr(8'h10, 8'h3c);
    wr(8'h11, 8'he7);
    wr(8'h0b, 8'hff);
    rd(8'h10, 8'h3c, "backup0");
    rd(8'h11, 8'he7, "backup1");
    rd(8'h0b, 8'h00, "reserved wr");
    rd(8'h20, 8'h00, "unmapped");
    final_report();
  end
endmodule
`default_nettype wire
